// >>> logic/energy_pulse_meter.sv
// Notes on behaviour
// (RL1) clear input acts only in cumulation mode
// (RL2) count four pulse inputs only in impulse mode
// (RL3) report four values: Wh and VArh
// (RL4) boundaries at period multiples from midnight
// (RL5) any parameter write zeroes all totals
// (RL6) after change: wait boundary, report next one
// (RL7) periods off,5,10,15,30,60; default thirty
// (RL8) non-cumulative totals zero after each report
// (RL9) each pulse adds scale 1..10000, default 100
// (RL10) period off: no boundaries, so never arms or accumulates
module energy_pulse_meter #(
  parameter int total_w = pulse_meter_pkg::total_w
) (
  input  wire logic               mclk,
  input  wire logic               rst_n,
  input  wire logic [4:0]         rtc_hour,          // real-time clock hour, 0..23
  input  wire logic [5:0]         rtc_minute,        // real-time clock minute, 0..59
  input  wire logic               rtc_minute_tick,   // one-cycle pulse as minute rolls
  input  wire logic               param_wr,          // one-cycle parameter write strobe
  input  wire logic [2:0]         report_period_sel, // period code
  input  wire logic               impulse_mode,      // 1 = impulse input selected
  input  wire logic               cumulate_mode,     // 1 = totals cumulate
  input  wire logic [13:0]        active_scale,      // energy per active pulse
  input  wire logic [13:0]        reactive_scale,    // energy per reactive pulse
  input  wire logic               total_clear_in,    // pin: clear cumulated totals
  input  wire logic               active_demand_pulse_in,
  input  wire logic               active_supply_pulse_in,
  input  wire logic               reactive_demand_pulse_in,
  input  wire logic               reactive_supply_pulse_in,
  output logic                    report_valid,      // one-cycle report strobe
  output logic [total_w-1:0]      demand_wh,
  output logic [total_w-1:0]      supply_wh,
  output logic [total_w-1:0]      demand_varh,
  output logic [total_w-1:0]      supply_varh,
  output logic [2:0]              period_active,     // period in force
  output logic                    accumulating       // armed and running
);

  // ************************************************************
  // synchronised input edges
  // ************************************************************
  logic [3:0] pulse_rise;   // dem p, sup p, dem q, sup q
  logic       clear_rise;   // clear input edge
  logic [3:0] pulse_pins;

  assign pulse_pins = {reactive_supply_pulse_in, reactive_demand_pulse_in,
                       active_supply_pulse_in, active_demand_pulse_in};

  // one synchroniser per pulse pin
  for (genvar g = 0; g < 4; g++) begin : g_sync
    pulse_edge_sync u_sync (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .pin_in   (pulse_pins[g]),
      .rise_out (pulse_rise[g])
    );
  end

  // clear pin synchroniser
  pulse_edge_sync u_clr_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .pin_in   (total_clear_in),
    .rise_out (clear_rise)
  );

  // ************************************************************
  // parameter registers
  // ************************************************************
  logic [2:0]  period_r,   period_nxt;
  logic        imp_r,      imp_nxt;
  logic        cum_r,      cum_nxt;
  logic [13:0] ascale_r,   ascale_nxt;
  logic [13:0] rscale_r,   rscale_nxt;

  // clamp a scale into its legal range
  function automatic logic [13:0] clamp_scale(input logic [13:0] s);
    if (s < pulse_meter_pkg::scale_min)      clamp_scale = pulse_meter_pkg::scale_min;
    else if (s > pulse_meter_pkg::scale_max) clamp_scale = pulse_meter_pkg::scale_max;
    else                                     clamp_scale = s;
  endfunction

  // capture parameters on write
  always_comb begin
    period_nxt = period_r;
    imp_nxt    = imp_r;
    cum_nxt    = cum_r;
    ascale_nxt = ascale_r;
    rscale_nxt = rscale_r;
    if (param_wr) begin
      // (RL7) unknown codes fall back to off
      period_nxt = (report_period_sel > 3'h5) ? 3'h0 : report_period_sel;
      imp_nxt    = impulse_mode;
      cum_nxt    = cumulate_mode;
      // (RL9) scale range clamp
      ascale_nxt = clamp_scale(active_scale);
      rscale_nxt = clamp_scale(reactive_scale);
    end
  end

  // parameter storage, defaults after reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      // (RL7) thirty minute default
      period_r <= pulse_meter_pkg::period_dflt;
      imp_r    <= 1'b1;
      cum_r    <= 1'b0;
      ascale_r <= pulse_meter_pkg::scale_dflt;
      rscale_r <= pulse_meter_pkg::scale_dflt;
    end else begin
      period_r <= period_nxt;
      imp_r    <= imp_nxt;
      cum_r    <= cum_nxt;
      ascale_r <= ascale_nxt;
      rscale_r <= rscale_nxt;
    end
  end

  // ************************************************************
  // interval boundary detection
  // ************************************************************
  logic [10:0] min_of_day;   // minutes since midnight
  logic [5:0]  per_min;      // period length in minutes
  logic        boundary;     // one-cycle boundary strobe

  assign min_of_day = 11'(rtc_hour) * 11'h03c + 11'(rtc_minute);
  assign per_min    = pulse_meter_pkg::period_minutes(period_r);

  // (RL4) multiples of period from midnight
  // (RL10) off period gives no boundary
  assign boundary = rtc_minute_tick && (per_min != 6'h00) &&
                    ((min_of_day % 11'(per_min)) == 11'h000);

  // ************************************************************
  // arming state machine
  // ************************************************************
  pulse_meter_pkg::arm_t arm_r, arm_nxt;

  // wait for first boundary after a change
  always_comb begin
    arm_nxt = arm_r;
    case (arm_r)
      pulse_meter_pkg::st_wait_start: if (boundary) arm_nxt = pulse_meter_pkg::st_run;
      pulse_meter_pkg::st_run:        arm_nxt = pulse_meter_pkg::st_run;
      default:                        arm_nxt = pulse_meter_pkg::st_wait_start;
    endcase
    // (RL6) change restarts the wait
    if (param_wr) arm_nxt = pulse_meter_pkg::st_wait_start;
  end

  // arming register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) arm_r <= pulse_meter_pkg::st_wait_start;
    else        arm_r <= arm_nxt;
  end

  // ************************************************************
  // accumulators and report
  // ************************************************************
  logic [total_w-1:0] tot_r   [4];
  logic [total_w-1:0] tot_nxt [4];
  logic [total_w-1:0] rep_r   [4];
  logic [total_w-1:0] rep_nxt [4];
  logic               rep_v_r, rep_v_nxt;
  logic               running;
  logic               do_report;

  assign running   = (arm_r == pulse_meter_pkg::st_run);
  assign do_report = running && boundary && !param_wr;

  // totals, clears and reports
  always_comb begin
    rep_v_nxt = do_report;
    for (int i = 0; i < 4; i++) begin
      rep_nxt[i] = rep_r[i];
      tot_nxt[i] = tot_r[i];
      // (RL3) snapshot for event values
      if (do_report) rep_nxt[i] = tot_r[i];
      // (RL8) non-cumulative restart per interval
      if (do_report && !cum_r) tot_nxt[i] = '0;
      // (RL1) clear only in cumulation mode
      if (clear_rise && cum_r) tot_nxt[i] = '0;
      // (RL2) count only in impulse mode
      if (running && imp_r && pulse_rise[i])
        tot_nxt[i] = tot_nxt[i] + total_w'((i < 2) ? ascale_r : rscale_r);
      // (RL5) parameter write clears totals
      if (param_wr) tot_nxt[i] = '0;
    end
  end

  // accumulator registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rep_v_r <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        tot_r[i] <= '0;
        rep_r[i] <= '0;
      end
    end else begin
      rep_v_r <= rep_v_nxt;
      for (int i = 0; i < 4; i++) begin
        tot_r[i] <= tot_nxt[i];
        rep_r[i] <= rep_nxt[i];
      end
    end
  end

  assign report_valid  = rep_v_r;
  assign demand_wh     = rep_r[0];
  assign supply_wh     = rep_r[1];
  assign demand_varh   = rep_r[2];
  assign supply_varh   = rep_r[3];
  assign period_active = period_r;
  assign accumulating  = running;

  // ************************************************************
  // assertions
  // ************************************************************
  property p_clear_ignored;  // (RL1)
    @(posedge mclk) disable iff (!rst_n)
      (clear_rise && !cum_r && !param_wr && !do_report && pulse_rise == 4'h0)
        |=> (tot_r[0] == $past(tot_r[0]));
  endproperty
  a_clear_ignored: assert property (p_clear_ignored) else $error("clear acted off mode");

  property p_no_count;  // (RL2)
    @(posedge mclk) disable iff (!rst_n)
      (!imp_r && !param_wr && !do_report && !clear_rise)
        |=> (tot_r[1] == $past(tot_r[1]));
  endproperty
  a_no_count: assert property (p_no_count) else $error("count outside impulse mode");

  property p_report_value;  // (RL3)
    @(posedge mclk) disable iff (!rst_n)
      do_report |=> (report_valid && demand_varh == $past(tot_r[2]));
  endproperty
  a_report_value: assert property (p_report_value) else $error("report value wrong");

  property p_boundary_aligned;  // (RL4)
    @(posedge mclk) disable iff (!rst_n)
      report_valid |-> $past(rtc_minute_tick) && $past(per_min) != 6'h00;
  endproperty
  a_boundary_aligned: assert property (p_boundary_aligned) else $error("report off boundary");

  property p_param_clear;  // (RL5)
    @(posedge mclk) disable iff (!rst_n)
      param_wr |=> (tot_r[0] == '0 && tot_r[3] == '0 && arm_r == pulse_meter_pkg::st_wait_start);
  endproperty
  a_param_clear: assert property (p_param_clear) else $error("totals not cleared");

  property p_first_wait;  // (RL6)
    @(posedge mclk) disable iff (!rst_n)
      (!running && boundary) |=> !report_valid;
  endproperty
  a_first_wait: assert property (p_first_wait) else $error("report on first boundary");

  property p_noncum_zero;  // (RL8)
    @(posedge mclk) disable iff (!rst_n)
      (do_report && !cum_r && pulse_rise == 4'h0) |=> tot_r[1] == '0;
  endproperty
  a_noncum_zero: assert property (p_noncum_zero) else $error("total kept after report");

  property p_scale_add;  // (RL9)
    @(posedge mclk) disable iff (!rst_n)
      (running && imp_r && pulse_rise[0] && !do_report && !clear_rise && !param_wr)
        |=> tot_r[0] == $past(tot_r[0]) + total_w'($past(ascale_r));
  endproperty
  a_scale_add: assert property (p_scale_add) else $error("pulse scale not added");

  property p_off_silent;  // (RL10)
    @(posedge mclk) disable iff (!rst_n)
      (period_r == 3'h0) |-> !boundary;
  endproperty
  a_off_silent: assert property (p_off_silent) else $error("boundary while off");

  c_report:  cover property (@(posedge mclk) disable iff (!rst_n) report_valid);
  c_cum_clr: cover property (@(posedge mclk) disable iff (!rst_n) clear_rise && cum_r);
  c_arm:     cover property (@(posedge mclk) disable iff (!rst_n) param_wr ##[1:1000] running);

endmodule // energy_pulse_meter

// >>> logic/pulse_meter_pkg.sv
package pulse_meter_pkg;

  // ************************************************************
  // period selection codes
  // ************************************************************
  typedef enum logic [2:0] {
    per_off = 3'h0,  // no boundaries, no reports
    per_5   = 3'h1,
    per_10  = 3'h2,
    per_15  = 3'h3,
    per_30  = 3'h4,
    per_60  = 3'h5
  } period_t;

  // ************************************************************
  // widths and defaults
  // ************************************************************
  localparam int          total_w       = 48;             // energy total width
  localparam int          scale_w       = 14;             // pulse scale width
  localparam logic [13:0] scale_min     = 14'h0001;       // least scale
  localparam logic [13:0] scale_max     = 14'h2710;       // greatest scale, 10000
  localparam logic [13:0] scale_dflt    = 14'h0064;       // default scale, 100
  localparam logic [2:0]  period_dflt   = 3'h4;           // 30 min after reset
  localparam int          n_chan        = 4;              // dem p, sup p, dem q, sup q

  // ************************************************************
  // accumulation arming states
  // ************************************************************
  typedef enum logic [1:0] {
    st_wait_start = 2'h0,  // waiting for first boundary after change
    st_run        = 2'h1   // accumulating, reports at boundaries
  } arm_t;

  // minute length of each period code
  function automatic logic [5:0] period_minutes(input logic [2:0] sel);
    case (sel)
      3'h1:    period_minutes = 6'h05;
      3'h2:    period_minutes = 6'h0a;
      3'h3:    period_minutes = 6'h0f;
      3'h4:    period_minutes = 6'h1e;
      3'h5:    period_minutes = 6'h3c;
      default: period_minutes = 6'h00;
    endcase
  endfunction

endpackage

// >>> logic/pulse_edge_sync.sv
// ************************************************************
// two-stage synchroniser and rising edge detector
// ************************************************************
module pulse_edge_sync (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic pin_in,   // asynchronous pin
  output logic      rise_out  // one-cycle pulse on rising edge
);

  logic meta_r;   // first stage, read only by sync_r
  logic sync_r;   // second stage
  logic prev_r;   // delayed for edge detection
  logic rise_nxt;

  // edge when the synchronised level goes high
  always_comb begin
    rise_nxt = sync_r & ~prev_r;
  end

  // register chain
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r   <= 1'b0;
      sync_r   <= 1'b0;
      prev_r   <= 1'b0;
      rise_out <= 1'b0;
    end else begin
      meta_r   <= pin_in;
      sync_r   <= meta_r;
      prev_r   <= sync_r;
      rise_out <= rise_nxt;
    end
  end

endmodule // pulse_edge_sync

// >>> test/meter_pulse_src.sv
// ************************************************************
// energy meter pulse outputs
// ************************************************************
module meter_pulse_src (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [3:0] go,      // one-cycle request, one pulse per set bit
  output logic      [3:0] pin_out  // pulse outputs, low when idle
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] mask_r;   // channels of the pulse in flight
  logic [2:0] phase_r;  // 0 idle, 1..3 high, 4..6 low
  // pulse sequencer: three cycles high, three low
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mask_r  <= 4'h0;
      phase_r <= 3'h0;
    end else if (phase_r == 3'h0) begin
      if (go != 4'h0) begin
        mask_r  <= go;
        phase_r <= 3'h1;
      end
    end else begin
      phase_r <= (phase_r == 3'h6) ? 3'h0 : phase_r + 3'h1;
    end
  end
  assign pin_out = (phase_r != 3'h0 && phase_r <= 3'h3) ? mask_r : 4'h0;
endmodule // meter_pulse_src

// >>> test/test_energy_pulse_interval_metering.sv
module test_energy_pulse_interval_metering;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk, rst_n, tick, param_wr, imp, cum, clr;
  logic [4:0]  hr;      // clock hour
  logic [5:0]  mn;      // clock minute
  logic [2:0]  per;     // period code to write
  logic [13:0] asc;     // active scale to write
  logic [13:0] rsc;     // reactive scale to write
  logic [3:0]  go;      // pulse requests to the meter model
  wire  [3:0]  pin;     // meter pulse pins
  logic        rep, acc;
  logic [47:0] dwh, swh, dvh, svh;
  logic [2:0]  pact;
  int          n_errors, checked, nrep;
  // ************************************************************
  // clock, parts
  // ************************************************************
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  meter_pulse_src SRC (.mclk(mclk), .rst_n(rst_n), .go(go), .pin_out(pin));
  energy_pulse_meter DUT (
    .mclk(mclk), .rst_n(rst_n), .rtc_hour(hr), .rtc_minute(mn), .rtc_minute_tick(tick),
    .param_wr(param_wr), .report_period_sel(per), .impulse_mode(imp), .cumulate_mode(cum),
    .active_scale(asc), .reactive_scale(rsc), .total_clear_in(clr),
    .active_demand_pulse_in(pin[0]), .active_supply_pulse_in(pin[1]),
    .reactive_demand_pulse_in(pin[2]), .reactive_supply_pulse_in(pin[3]),
    .report_valid(rep), .demand_wh(dwh), .supply_wh(swh), .demand_varh(dvh),
    .supply_varh(svh), .period_active(pact), .accumulating(acc));
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // next minute; report strobe looked at the cycle after the tick
  task automatic tick_min();
    repeat (3) @(posedge mclk);
    #1;
    if (mn == 6'h3b) begin
      mn = 6'h00;
      hr = hr + 5'h01;
    end else begin
      mn = mn + 6'h01;
    end
    tick = 1'b1;
    @(posedge mclk);
    #1;
    tick = 1'b0;
    if (rep === 1'b1) nrep++;
  endtask
  task automatic run_to(input logic [4:0] h, input logic [5:0] m);
    nrep = 0;
    while (hr != h || mn != m) tick_min();
  endtask
  task automatic wr(input logic [2:0] p, input logic i, c, input logic [13:0] a, r);
    @(posedge mclk);
    #1;
    {per, imp, cum, asc, rsc, param_wr} = {p, i, c, a, r, 1'b1};
    @(posedge mclk);
    #1;
    param_wr = 1'b0;
    @(posedge mclk);
    #1;
    check(48'(pact), 48'(p));
  endtask
  task automatic pulse(input logic [3:0] mask, input int n);
    repeat (n) begin
      @(posedge mclk);
      #1;
      go = mask;
      @(posedge mclk);
      #1;
      go = 4'h0;
      repeat (8) @(posedge mclk);
    end
  endtask
  task automatic clear_pin();
    @(posedge mclk);
    #1;
    clr = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    clr = 1'b0;
    repeat (6) @(posedge mclk);
  endtask
  task automatic totals(input logic [47:0] a, b, c, d);
    check(dwh, a);
    check(swh, b);
    check(dvh, c);
    check(svh, d);
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_first();
    check(48'(pact), 48'h4);
    check(48'(acc), 48'h0);
    wr(pulse_meter_pkg::per_15, 1'b1, 1'b0, 14'h0003, 14'h0005);
    pulse(4'hf, 1);
    run_to(5'h00, 6'h0f);
    check(48'(nrep), 48'h0);
    check(48'(acc), 48'h1);
    pulse(4'h1, 2);
    pulse(4'he, 1);
    clear_pin();
    run_to(5'h00, 6'h1e);
    check(48'(nrep), 48'h1);
    totals(48'h6, 48'h3, 48'h5, 48'h5);
    run_to(5'h00, 6'h2d);
    totals(48'h0, 48'h0, 48'h0, 48'h0);
    $display("t_first done");
  endtask
  task automatic t_cum();
    wr(pulse_meter_pkg::per_5, 1'b1, 1'b1, 14'h3fff, 14'h0000);
    run_to(5'h00, 6'h32);
    pulse(4'h1, 1);
    pulse(4'h8, 2);
    run_to(5'h00, 6'h37);
    totals(48'h2710, 48'h0, 48'h0, 48'h2);
    pulse(4'h8, 1);
    run_to(5'h01, 6'h00);
    totals(48'h2710, 48'h0, 48'h0, 48'h3);
    clear_pin();
    pulse(4'h8, 1);
    run_to(5'h01, 6'h05);
    totals(48'h0, 48'h0, 48'h0, 48'h1);
    pulse(4'h4, 1);
    wr(pulse_meter_pkg::per_5, 1'b1, 1'b1, 14'h3fff, 14'h0000);
    check(48'(acc), 48'h0);
    run_to(5'h01, 6'h0f);
    totals(48'h0, 48'h0, 48'h0, 48'h0);
    $display("t_cum done");
  endtask
  task automatic t_modes();
    wr(pulse_meter_pkg::per_5, 1'b0, 1'b0, 14'h0001, 14'h0001);
    run_to(5'h01, 6'h14);
    pulse(4'hf, 1);
    run_to(5'h01, 6'h19);
    check(48'(nrep), 48'h1);
    totals(48'h0, 48'h0, 48'h0, 48'h0);
    wr(pulse_meter_pkg::per_10, 1'b1, 1'b0, 14'h0001, 14'h0001);
    run_to(5'h02, 6'h00);
    // arms at 1:30, then reports at 1:40, 1:50 and 2:00
    check(48'(nrep), 48'h3);
    wr(pulse_meter_pkg::per_60, 1'b1, 1'b0, 14'h0001, 14'h0001);
    run_to(5'h03, 6'h3b);
    check(48'(nrep), 48'h0);
    run_to(5'h04, 6'h00);
    check(48'(nrep), 48'h1);
    wr(pulse_meter_pkg::per_off, 1'b1, 1'b0, 14'h0001, 14'h0001);
    run_to(5'h05, 6'h00);
    check(48'(nrep), 48'h0);
    $display("t_modes done");
  endtask
  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial begin
    {rst_n, tick, param_wr, imp, cum, clr, go} = 10'h0;
    {hr, mn, per, asc, rsc} = {5'h00, 6'h07, 3'h4, 14'h0064, 14'h0064};
    n_errors = 0;
    checked = 0;
    repeat (16) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    @(posedge mclk);
    #1;
    t_first();
    t_cum();
    t_modes();
    close_out();
  end
  initial begin
    #200000;
    n_errors++;
    close_out();
  end
endmodule // test_energy_pulse_interval_metering
